// ===== verilog/adc_route_cfg.svh
`ifndef ADC_ROUTE_CFG_SVH
`define ADC_ROUTE_CFG_SVH

// register indices; byte address is four times the index
`define IDX_RESERVED_A 6'h14
`define IDX_LEFT_ROUTE 6'h15
`define IDX_RIGHT_ROUTE 6'h16
`define IDX_RESERVED_B 6'h17

// reset values
`define RST_RESERVED 8'h78
`define RST_LEFT_ROUTE 8'h78
`define RST_RIGHT_ROUTE 8'h78

// field positions
`define BIT_DIFF 7
`define LVL_HI 6
`define LVL_LO 3
`define BIT_POWER 2
`define SS_HI 1
`define SS_LO 0
`define LEFT_WR_MASK 8'hF8

// level codes
`define LVL_MAX 4'h8
`define LVL_OFF 4'hF

// soft-step codes
`define SS_CODE_ONE 2'h0
`define SS_CODE_TWO 2'h1

// bus data
`define DATA_W 32
`define REG_W 8
`define ADDR_W 8

`endif

// ===== verilog/adc_route_pkg.sv
package adc_route_pkg;

   typedef enum logic [1:0] {
      SS_EVERY_SAMPLE,
      SS_EVERY_TWO,
      SS_DISABLED
   } softstep_t;

   typedef struct packed {
      logic diff;
      logic connect;
      logic [3:0] atten;
   } mixer_route_t;

endpackage

// ===== verilog/route_level_decode.sv
`timescale 1ns/100ps
`default_nettype none
`include "adc_route_cfg.svh"

module route_level_decode (
   // clock and reset
   input wire logic clock_i,
   input wire logic resetn_i,
   input wire logic ce_i,
   // register fields
   input wire logic diff_i,
   input wire logic [3:0] level_i,
   // decoded mixer routing
   output adc_route_pkg::mixer_route_t route_o
);

   adc_route_pkg::mixer_route_t route_d;
   adc_route_pkg::mixer_route_t route_q;

   always_comb begin
      route_d = route_q;
      if (ce_i) begin
         route_d.diff = diff_i;
         // reserved codes are treated as disconnected, the safe side
         route_d.connect = (level_i <= `LVL_MAX);
         route_d.atten = route_d.connect ? level_i : `LVL_OFF;
      end
   end

   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         route_q <= '{diff: 1'b0, connect: 1'b0, atten: `LVL_OFF};
      end else begin
         route_q <= route_d;
      end
   end

   assign route_o = route_q;

endmodule
`default_nettype wire

// ===== verilog/adc_input_route_regs.sv
// Notes on behaviour
// - bit 7 set pairs positive and negative pins differentially; clear is single-ended.
// - left routing bits 6..3 give attenuation 0 to -12 dB, 1.5 dB steps.
// - right routing bits 6..3 give the same attenuation coding.
// - any valid level code connects the input to that mixer.
// - level code 1111 disconnects the input; it is the reset value.
// - right routing bit 2 powers the right channel; reset is down.
// - right bits 1..0: every sample, every two samples, else disabled.
//
// The Avalon-MM register port was chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "adc_route_cfg.svh"

module adc_input_route_regs (
   // clock, reset, enable
   input wire logic clock_i,
   input wire logic resetn_i,
   input wire logic ce_i,
   // avalon-mm slave
   input wire logic [`ADDR_W-1:0] address_i,
   input wire logic [3:0] byteenable_i,
   input wire logic read_i,
   input wire logic write_i,
   input wire logic [`DATA_W-1:0] writedata_i,
   output logic [`DATA_W-1:0] readdata_o,
   output logic waitrequest_o,
   // routing to the mixers
   output adc_route_pkg::mixer_route_t left_route_o,
   output adc_route_pkg::mixer_route_t right_route_o,
   output logic right_power_o,
   output adc_route_pkg::softstep_t right_softstep_o,
   output logic diff_mismatch_o
);

   logic [`REG_W-1:0] left_q, left_d;
   logic [`REG_W-1:0] right_q, right_d;
   logic [`REG_W-1:0] rsvd_b_q, rsvd_b_d;
   logic wait_q, wait_d;
   logic [`DATA_W-1:0] rdata_q, rdata_d;
   adc_route_pkg::softstep_t ss_q, ss_d;
   logic mismatch_q, mismatch_d;
   logic req;
   logic commit;
   logic lane0;

   function automatic logic hit(input logic [`ADDR_W-1:0] addr, input logic [5:0] idx);
      hit = (addr == {idx, 2'b00});
   endfunction

   function automatic adc_route_pkg::softstep_t ss_decode(input logic [1:0] code);
      unique case (code)
         `SS_CODE_ONE: ss_decode = adc_route_pkg::SS_EVERY_SAMPLE;
         `SS_CODE_TWO: ss_decode = adc_route_pkg::SS_EVERY_TWO;
         default: ss_decode = adc_route_pkg::SS_DISABLED;
      endcase
   endfunction

   assign req = read_i | write_i;
   // request completes on the edge where waitrequest is seen low
   assign commit = req & ~wait_q;
   assign lane0 = byteenable_i[0];

   // bus handshake and read data
   always_comb begin
      wait_d = wait_q;
      rdata_d = rdata_q;
      if (ce_i) begin
         // one idle cycle per access gives the read mux a full register stage
         wait_d = ~(req & wait_q);
         if (read_i & wait_q) begin
            rdata_d = '0;
            if (hit(address_i, `IDX_RESERVED_A)) begin
               rdata_d[`REG_W-1:0] = `RST_RESERVED;
            end else if (hit(address_i, `IDX_LEFT_ROUTE)) begin
               rdata_d[`REG_W-1:0] = left_q & `LEFT_WR_MASK;
            end else if (hit(address_i, `IDX_RIGHT_ROUTE)) begin
               rdata_d[`REG_W-1:0] = right_q;
            end else if (hit(address_i, `IDX_RESERVED_B)) begin
               rdata_d[`REG_W-1:0] = rsvd_b_q;
            end
         end
      end
   end

   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         wait_q <= 1'b1;
         rdata_q <= '0;
      end else begin
         wait_q <= wait_d;
         rdata_q <= rdata_d;
      end
   end

   // register storage
   always_comb begin
      left_d = left_q;
      right_d = right_q;
      rsvd_b_d = rsvd_b_q;
      if (ce_i & commit & write_i & lane0) begin
         if (hit(address_i, `IDX_LEFT_ROUTE)) begin
            left_d = writedata_i[`REG_W-1:0] & `LEFT_WR_MASK;
         end
         if (hit(address_i, `IDX_RIGHT_ROUTE)) begin
            right_d = writedata_i[`REG_W-1:0];
         end
         // read/write per the map, even though software should leave it
         if (hit(address_i, `IDX_RESERVED_B)) begin
            rsvd_b_d = writedata_i[`REG_W-1:0];
         end
      end
   end

   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         left_q <= `RST_LEFT_ROUTE;
         right_q <= `RST_RIGHT_ROUTE;
         rsvd_b_q <= `RST_RESERVED;
      end else begin
         left_q <= left_d;
         right_q <= right_d;
         rsvd_b_q <= rsvd_b_d;
      end
   end

   // soft-step decode and mismatch flag
   always_comb begin
      ss_d = ss_q;
      mismatch_d = mismatch_q;
      if (ce_i) begin
         ss_d = ss_decode(right_q[`SS_HI:`SS_LO]);
         // observes software keeping both paths in the same pin mode
         mismatch_d = left_route_o.connect & right_route_o.connect &
                      (left_route_o.diff != right_route_o.diff);
      end
   end

   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         ss_q <= adc_route_pkg::SS_EVERY_SAMPLE;
         mismatch_q <= 1'b0;
      end else begin
         ss_q <= ss_d;
         mismatch_q <= mismatch_d;
      end
   end

   route_level_decode u_left (
      .clock_i(clock_i),
      .resetn_i(resetn_i),
      .ce_i(ce_i),
      .diff_i(left_q[`BIT_DIFF]),
      .level_i(left_q[`LVL_HI:`LVL_LO]),
      .route_o(left_route_o)
   );

   route_level_decode u_right (
      .clock_i(clock_i),
      .resetn_i(resetn_i),
      .ce_i(ce_i),
      .diff_i(right_q[`BIT_DIFF]),
      .level_i(right_q[`LVL_HI:`LVL_LO]),
      .route_o(right_route_o)
   );

   assign readdata_o = rdata_q;
   assign waitrequest_o = wait_q;
   assign right_power_o = right_q[`BIT_POWER];
   assign right_softstep_o = ss_q;
   assign diff_mismatch_o = mismatch_q;

endmodule
`default_nettype wire

// ===== tb/adc_route_props.sv
`timescale 1ns/100ps
`default_nettype none
module adc_route_props (
   // watched ports
   input wire logic clock_i,
   input wire logic resetn_i,
   input wire logic [7:0] address_i,
   input wire logic write_i,
   input wire logic [31:0] writedata_i,
   input wire logic waitrequest_o,
   input wire adc_route_pkg::mixer_route_t left_route_o,
   input wire adc_route_pkg::mixer_route_t right_route_o,
   input wire logic right_power_o,
   input wire adc_route_pkg::softstep_t right_softstep_o
);
   wire logic acc = write_i & ~waitrequest_o;
   wire logic wl = acc & (address_i == 8'h54);
   wire logic wr = acc & (address_i == 8'h58);
   wire logic [7:0] wd = writedata_i[7:0];
   default clocking @(posedge clock_i); endclocking
   default disable iff (!resetn_i);
   a_left_diff: assert property (wl |-> ##2 left_route_o.diff == $past(wd[7], 2))
      else $error("left diff");
   a_left_on: assert property (wl && wd[6:3] <= 4'h8 |-> ##2 left_route_o.connect
      && left_route_o.atten == $past(wd[6:3], 2)) else $error("left level");
   a_right_on: assert property (wr && wd[6:3] <= 4'h8 |-> ##2 right_route_o.connect
      && right_route_o.atten == $past(wd[6:3], 2)) else $error("right level");
   a_left_off: assert property (wl && wd[6:3] == 4'hF |-> ##2 !left_route_o.connect)
      else $error("left off");
   a_power_bit: assert property (wr |=> right_power_o == $past(wd[2]))
      else $error("power");
   a_soft_step: assert property (wr |-> ##2 right_softstep_o ==
      ($past(wd[1], 2) ? 2'h2 : {1'b0, $past(wd[0], 2)})) else $error("soft step");
   a_route_hold: assert property (!(wl | wr) ##1 !(wl | wr) |=>
      $stable(left_route_o) && $stable(right_route_o)) else $error("route moved");
   a_power_hold: assert property (!wr |=> $stable(right_power_o))
      else $error("power moved");
endmodule
bind adc_input_route_regs adc_route_props adc_route_props_i (.clock_i, .resetn_i, .address_i,
   .write_i, .writedata_i, .waitrequest_o, .left_route_o, .right_route_o, .right_power_o,
   .right_softstep_o);
`default_nettype wire

// ===== tb/testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
   logic clock_i = 0, resetn_i = 0, read_i = 0, write_i = 0, waitrequest_o, right_power_o;
   logic diff_mismatch_o;
   logic [31:0] rd;
   logic [7:0] address_i = 8'h00;
   logic [31:0] writedata_i = 32'h0, readdata_o;
   adc_route_pkg::mixer_route_t left_route_o, right_route_o;
   adc_route_pkg::softstep_t right_softstep_o;
   int fail_count = 0, comparisons = 0;
   // address, write, read-back, route; level codes stay legal
   logic [31:0] rows [6] = '{32'h54878030, 32'h54404018, 32'h5478780F, 32'h58070710,
      32'h58C5C538, 32'h587A7A0F};
   adc_input_route_regs adc_input_route_regs_i (.clock_i, .resetn_i, .ce_i(1'b1), .address_i,
      .byteenable_i(4'hF), .read_i, .write_i, .writedata_i, .readdata_o, .waitrequest_o,
      .left_route_o, .right_route_o, .right_power_o, .right_softstep_o, .diff_mismatch_o);
   always #12.5 clock_i = ~clock_i;
   task check(input logic [31:0] seen, exp);
      comparisons++;
      if (seen !== exp) begin
         fail_count++;
         $display("unexpected %0t %h %h", $time, seen, exp);
      end
   endtask
   task results;
      $display("%0d of %0d failed", fail_count, comparisons);
      if (fail_count == 0 && comparisons > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // wait and read data taken at the rising edge, before the design updates
   task xfer(input logic w, input logic [7:0] a, d);
      int n;
      n = 0;
      {address_i, writedata_i, write_i, read_i} <= {a, 24'h0, d, w, !w};
      do begin
         @(posedge clock_i);
         n++;
      end while (waitrequest_o !== 1'b0 && n < 20);
      rd = readdata_o;
      if (waitrequest_o !== 1'b0) begin
         fail_count++;
         results;
      end
      {write_i, read_i} <= 2'b00;
      @(posedge clock_i);
   endtask
   initial begin
      repeat (5) @(posedge clock_i);
      resetn_i <= 1;
      @(posedge clock_i);
      foreach (rows[i]) begin
         xfer(1, rows[i][31:24], rows[i][23:16]);
         xfer(0, rows[i][31:24], 8'h00);
         check(rd, rows[i][15:8]);
         check(rows[i][27] ? right_route_o : left_route_o, rows[i][7:0]);
         if (rows[i][27]) begin
            check(right_power_o, rows[i][18]);
            check(right_softstep_o, rows[i][17] ? 2'h2 : rows[i][16]);
         end
      end
      // reserved registers are only read, never written
      xfer(0, 8'h50, 8'h00);
      check(rd, 32'h78);
      xfer(0, 8'h5C, 8'h00);
      check(rd, 32'h78);
      // same pin mode on both paths keeps the flag low
      xfer(1, 8'h54, 8'hC0);
      xfer(1, 8'h58, 8'h80);
      repeat (3) @(posedge clock_i);
      check(diff_mismatch_o, 1'b0);
      // awkward case: pairing broken on purpose, flag must rise
      xfer(1, 8'h58, 8'h00);
      repeat (3) @(posedge clock_i);
      check(diff_mismatch_o, 1'b1);
      xfer(1, 8'h60, 8'hFF);
      xfer(0, 8'h60, 8'h00);
      check(rd, 32'h0);
      resetn_i <= 0;
      repeat (5) @(posedge clock_i);
      check({left_route_o, right_route_o, right_power_o}, 13'h079E);
      resetn_i <= 1;
      @(posedge clock_i);
      xfer(0, 8'h58, 8'h00);
      check(rd, 32'h78);
      results;
   end
endmodule
`default_nettype wire
